// file: pvic_ctrl.sv
// Top of the priority vector interrupt controller
// Operation
// R01: Fifteen sources with fixed vectors, reset highest, then watchdog down to ext5.
// R02: Each request held in its own flag until software clears it.
// R03: Pending flag interrupts only when its mask bit and global enable set.
// R04: Enable instruction sets global enable; disable instruction clears it.
// R05: Taken interrupt redirects next fetch to that source's vector.
// R06: Service routine clears its flag before return and before re-enabling.
// R07: Status register 2 flags set regardless of mask, except input change; GATED_SET_MASK is zero, so input change also sets when masked.
// R08: Return-from-interrupt also sets global enable like the enable instruction.
// R09: Several pending enabled requests: lowest priority number served first.
// R10: Taking an interrupt clears global enable until return or enable.
`timescale 1ns/1ps
module pvic_ctrl #(
  parameter int unsigned NUM_SRC = pvic_pkg::NUM_SRC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [NUM_SRC-1:0] event_in,
  input wire logic [NUM_SRC-1:0] flag_clr_in,
  input wire logic [NUM_SRC-1:0] mask_wdata_in,
  input wire logic mask_we_in,
  input wire pvic_pkg::pvic_instr_t instr_in,
  input wire logic fetch_ack_in,
  output pvic_pkg::pvic_take_t take_out,
  output logic [NUM_SRC-1:0] flags_out,
  output logic [NUM_SRC-1:0] mask_out,
  output logic gie_out
);
  if (NUM_SRC != pvic_pkg::NUM_SRC) begin : g_chk
    $error("pvic_ctrl: vector table holds exactly fifteen sources");
  end

  typedef struct packed {
    logic [NUM_SRC-1:0] flags;
    logic [NUM_SRC-1:0] mask;
    logic gie;
    pvic_pkg::pvic_take_t take;
  } pvic_state_t;

  pvic_state_t st_r;
  pvic_state_t st_nxt;
  logic [NUM_SRC-1:0] set_vec;
  logic [NUM_SRC-1:0] pend_vec;
  logic pick_any;
  logic [pvic_pkg::IDX_W-1:0] pick_idx;

  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    // Gated sources only latch while enabled; others always latch
    assign set_vec[g] = event_in[g] &
      (~pvic_pkg::GATED_SET_MASK[g] | (st_r.mask[g] & st_r.gie)); // see R07
    assign pend_vec[g] = st_r.flags[g] & st_r.mask[g] & st_r.gie; // see R03
  end

  pvic_pick #(.N(NUM_SRC)) u_pick (
    .req_in(pend_vec),
    .any_out(pick_any),
    .idx_out(pick_idx)
  );

  always_comb begin
    st_nxt = st_r;
    // Set wins over a clear in the same cycle
    st_nxt.flags = (st_r.flags & ~flag_clr_in) | set_vec; // see R02 see R06
    if (mask_we_in) begin
      st_nxt.mask = mask_wdata_in;
    end
    if (instr_in.disable_instr) begin
      st_nxt.gie = 1'b0; // see R04
    end
    if (instr_in.enable_instr || instr_in.return_instr) begin
      st_nxt.gie = 1'b1; // see R04 see R08
    end
    if (st_r.take.valid) begin
      // Redirect held until fetch logic consumes it
      if (fetch_ack_in) begin
        st_nxt.take.valid = 1'b0;
      end
    end else if (pick_any) begin
      st_nxt.take.valid = 1'b1;
      st_nxt.take.src = pick_idx; // see R09
      st_nxt.take.vector =
        pvic_pkg::VEC_TABLE[pick_idx*pvic_pkg::VEC_W +: pvic_pkg::VEC_W]; // see R01 see R05
      st_nxt.gie = 1'b0; // see R10
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r.flags <= pvic_pkg::FLAG_RST;
      st_r.mask <= pvic_pkg::MASK_RST;
      st_r.gie <= pvic_pkg::GIE_RST;
      st_r.take.valid <= 1'b0;
      st_r.take.vector <= pvic_pkg::VEC_RESET; // see R01
      st_r.take.src <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign take_out = st_r.take;
  assign flags_out = st_r.flags;
  assign mask_out = st_r.mask;
  assign gie_out = st_r.gie;
endmodule // pvic_ctrl

// file: pvic_pkg.sv
// Package with constants and types of the priority vector interrupt controller
package pvic_pkg;
  localparam int unsigned NUM_SRC = 15;
  localparam int unsigned VEC_W = 12;
  localparam int unsigned IDX_W = 4;
  // Source index is priority number minus one; reset has no flag
  localparam logic [VEC_W-1:0] VEC_RESET = 12'h000;
  localparam logic [NUM_SRC*VEC_W-1:0] VEC_TABLE = {
    12'h036, 12'h033, 12'h030, 12'h02A, 12'h027,
    12'h024, 12'h021, 12'h01B, 12'h018, 12'h015,
    12'h012, 12'h00F, 12'h009, 12'h006, 12'h003};
  // Sources whose flag is set only while enabled (none: input change in status reg 2 is not gated)
  localparam logic [NUM_SRC-1:0] GATED_SET_MASK = 15'h0000;
  localparam logic [NUM_SRC-1:0] FLAG_RST = 15'h0000;
  localparam logic [NUM_SRC-1:0] MASK_RST = 15'h0000;
  localparam logic GIE_RST = 1'b0;

  typedef struct packed {
    logic enable_instr;
    logic disable_instr;
    logic return_instr;
  } pvic_instr_t;

  typedef struct packed {
    logic valid;
    logic [VEC_W-1:0] vector;
    logic [IDX_W-1:0] src;
  } pvic_take_t;
endpackage

// file: pvic_pick.sv
// Fixed priority picker of the interrupt controller
`timescale 1ns/1ps
module pvic_pick #(
  parameter int unsigned N = pvic_pkg::NUM_SRC
) (
  input wire logic [N-1:0] req_in,
  output logic any_out,
  output logic [pvic_pkg::IDX_W-1:0] idx_out
);
  if (N > (1 << pvic_pkg::IDX_W)) begin : g_chk
    $error("pvic_pick: too many sources");
  end
  always_comb begin
    any_out = 1'b0;
    idx_out = '0;
    // Scan from low priority upward so the lowest index wins
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        any_out = 1'b1;
        idx_out = pvic_pkg::IDX_W'(i); // see R09
      end
    end
  end
endmodule // pvic_pick

// file: pvic_chk_asserts.sv
// Port assertions of the interrupt controller
`timescale 1ns/1ps
module pvic_chk #(parameter int unsigned NUM_SRC = 15) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [NUM_SRC-1:0] event_in,
  input wire pvic_pkg::pvic_instr_t instr_in,
  input wire logic fetch_ack_in,
  input wire pvic_pkg::pvic_take_t take_out,
  input wire logic [NUM_SRC-1:0] flags_out,
  input wire logic [NUM_SRC-1:0] mask_out,
  input wire logic gie_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence take_s; $rose(take_out.valid); endsequence
  take_gie_a: assert property (take_s |-> !gie_out) else $error("gie kept");
  take_pick_a: assert property (take_s |-> $past(gie_out) && (1 << take_out.src) ==
    ($past(flags_out) & $past(mask_out) & ((2 << take_out.src) - 1))) else $error("pick");
  vec_map_a: assert property (take_out.valid |-> take_out.vector ==
    pvic_pkg::VEC_TABLE[take_out.src*12 +: 12]) else $error("vector");
  take_hold_a: assert property (take_out.valid && !fetch_ack_in |=> $stable(take_out))
    else $error("hold");
  ack_drop_a: assert property (take_out.valid && fetch_ack_in |=> !take_out.valid)
    else $error("ack");
  flag_set_a: assert property (##1 (flags_out & $past(event_in)) == $past(event_in))
    else $error("flag");
  gie_set_a: assert property (instr_in[0] || instr_in[2] |=> gie_out || $rose(take_out.valid))
    else $error("gie set");
  gie_clr_a: assert property (instr_in == 3'h2 |=> !gie_out) else $error("gie clr");
endmodule // pvic_chk

// file: pvic_core_model.sv
// Core model: takes the redirect, clears the flag, then returns
`timescale 1ns/1ps
module pvic_core_model (
  input wire logic clk_in,
  input wire logic [3:0] wait_in,
  input wire pvic_pkg::pvic_take_t take_in,
  output logic ack_out = 0,
  output logic [14:0] clr_out = 0,
  output logic ret_out = 0
);
  always @(posedge clk_in iff take_in.valid) begin
    repeat (wait_in) @(posedge clk_in);
    #1 ack_out = 1;
    @(posedge clk_in) #1 ack_out = 0;
    clr_out = 15'h1 << take_in.src;
    @(posedge clk_in) #1 clr_out = 0;
    ret_out = 1; // Return only after the clear, or it fires again
    @(posedge clk_in) #1 ret_out = 0;
  end
endmodule // pvic_core_model

// file: testbench.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
bind pvic_ctrl pvic_chk #(.NUM_SRC(NUM_SRC)) i_chk (.*);
module testbench;
  logic clk_in = 0, rst_n_in = 0, mask_we_in = 0, ack, ret, gie_out;
  logic [14:0] event_in = 0, clr_r = 0, mask_wdata_in = 0, clr, ev, mk, flags_out, mask_out;
  logic [2:0] instr_r = 0;
  logic [3:0] wait_r = 0;
  pvic_pkg::pvic_take_t take_out;
  int seed = 66, error_cnt = 0, comparisons = 0, exp_q[$];
  always #12.5 clk_in = ~clk_in;
  pvic_ctrl i_dut (.clk_in, .rst_n_in, .event_in, .flag_clr_in(clr_r | clr), .mask_wdata_in,
    .mask_we_in, .instr_in(instr_r | 3'(ret)), .fetch_ack_in(ack), .take_out, .flags_out,
    .mask_out, .gie_out);
  pvic_core_model i_core (.clk_in, .wait_in(wait_r), .take_in(take_out), .ack_out(ack),
    .clr_out(clr), .ret_out(ret));
  task check(input logic [15:0] got, input logic [15:0] want);
    comparisons++;
    error_cnt += (got !== want);
    if (got !== want) $display("MISMATCH %0t: got %h want %h", $time, got, want);
  endtask
  task test_done(input int extra);
    error_cnt += extra;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial #1000000 test_done(1);
  int exp_src;
  always @(posedge clk_in) begin
    if ($rose(take_out.valid)) begin
      exp_src = exp_q.size() > 0 ? exp_q.pop_front() : 99;
      check(take_out.src, exp_src);
      check(take_out.vector, pvic_pkg::VEC_TABLE[exp_src*12 +: 12]);
    end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    #1 rst_n_in = 1;
    for (int t = 0; t < 24; t++) begin
      ev = t < 15 ? 15'h1 << t : 15'($random(seed));
      mk = t < 15 ? '1 : 15'($random(seed));
      wait_r = 4'($random(seed));
      for (int i = 0; i < 15; i++) if (ev[i] && mk[i]) exp_q.push_back(i);
      {mask_we_in, mask_wdata_in, instr_r} = {1'b1, mk, 3'h2};
      @(posedge clk_in) #1 {mask_we_in, instr_r, event_in} = {1'b0, 3'h0, ev};
      @(posedge clk_in) #1 {instr_r, event_in} = {3'h4, 15'h0};
      @(posedge clk_in) #1 instr_r = 0;
      for (int n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge clk_in);
      repeat (24) @(posedge clk_in);
      #1 check(flags_out, ev & ~mk);
      check(exp_q.size(), 0);
      check(mask_out, mk);
      check(gie_out, 1'b1);
      clr_r = '1;
      @(posedge clk_in) #1 clr_r = 0;
      $display("trial %0d done", t);
    end
    test_done(0);
  end
endmodule // testbench
